/* verilog/queue_flag_map.vh */
// Purpose: Constants for the queue level-flag reporting block
// Assumes: Included by bare name from the design file
// Notes: Definitions only
`ifndef QUEUE_FLAG_MAP_VH
`define QUEUE_FLAG_MAP_VH

`define NUM_QUEUES 8
`define QSEL_W 3
`define DEV_W 3
`define ADDR_W 6
`define LEVEL_W 12
`define PIN_W 28

// Register byte addresses
`define REG_CTRL 4'h0
`define REG_AE_THRESH 4'h4
`define REG_AF_THRESH 4'h8
`define REG_STATUS 4'hC
`define REG_ADDR_W 4

// Control fields
`define CTRL_BUS_EN 0
`define CTRL_MIRROR 1
`define CTRL_RESET 2'h1
`define AE_THRESH_RESET 12'h010
`define AF_THRESH_RESET 12'hFF0

// Bus width codes
`define WIDTH_X9 2'h0
`define WIDTH_X18 2'h1
`define WIDTH_X36 2'h2

`define HTRANS_NONSEQ_BIT 1
`define ZERO32 32'h00000000

`endif

/* verilog/queue_level_flags.v */
// Purpose: Almost-empty/almost-full discrete flags and per-queue flag buses
// Assumes: Read and write clocks arrive as pins on CORE_CLK; AHB-Lite slave
// Notes: Flag buses share lines in expansion, so each has an active-low enable
//
// What this block does
// - Input and output widths come from three straps; one port is always 36.
// - Almost-empty flag is low while read-selected queue is almost empty, read-clocked.
// - Almost-empty flag follows queue chosen by read address and enable.
// - Almost-full flag is low while write-selected queue is almost full, write-clocked.
// - Almost-full flag follows queue chosen by write address and enable.
// - In direct mode, the almost-empty and almost-full flags can be mirrored onto their queue's flag bus line.
// - Eight-bit read-side bus shows all queues, almost-empty or packet-ready.
// - Direct or polled bus operation is picked by flag-mode strap at master reset.
// - Both flag buses can go high-impedance for sharing between devices.
// - Direct read bus shows device addressed with empty strobe on read edge.
// - Polled read bus is reloaded on every rising read clock edge.
// - Read bus content follows packet-select strap taken at master reset.
// - Eight-bit write-side bus reports almost-full status of all queues.
// - Direct write bus shows device addressed with full strobe and enable.
// - Polled write bus is loaded in turn on rising write clock edges.
// - In polled mode, token output pulses high while this device holds the write bus.
// - Packet-select strap high means packet mode, low means almost-empty mode.
`include "queue_flag_map.vh"

module queue_level_flags (
   input wire CORE_CLK,
   input wire RST_N,
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   output reg [31:0] HRDATA,
   output wire HREADYOUT,
   output wire HRESP,
   input wire MASTER_RESET_N,
   input wire READ_CLK,
   input wire WRITE_CLK,
   input wire OUTPUT_WIDTH_STRAP,
   input wire INPUT_WIDTH_STRAP,
   input wire BUS_MATCHING_STRAP,
   input wire FLAG_MODE_STRAP,
   input wire PACKET_SELECT_STRAP,
   input wire [2:0] DEVICE_ID,
   input wire [5:0] READ_QUEUE_ADDRESS,
   input wire [5:0] WRITE_QUEUE_ADDRESS,
   input wire READ_ADDRESS_ENABLE,
   input wire WRITE_ADDRESS_ENABLE,
   input wire EMPTY_STATUS_STROBE,
   input wire FULL_STATUS_STROBE,
   input wire TOKEN_CHAIN_IN,
   input wire [95:0] QUEUE_LEVEL,
   input wire [7:0] PACKET_READY,
   output reg ALMOST_EMPTY_FLAG_N,
   output reg ALMOST_FULL_FLAG_N,
   output reg PACKET_READY_FLAG_N,
   output reg [7:0] READ_SIDE_FLAG_BUS,
   output wire READ_SIDE_FLAG_BUS_OE_N,
   output reg [7:0] WRITE_SIDE_FLAG_BUS,
   output wire WRITE_SIDE_FLAG_BUS_OE_N,
   output reg TOKEN_CHAIN_OUT,
   output reg [1:0] INPUT_BUS_WIDTH,
   output reg [1:0] OUTPUT_BUS_WIDTH
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers: every pin input passes two flops first
reg [`PIN_W-1:0] sync1;
reg [`PIN_W-1:0] sync2;
wire [`PIN_W-1:0] pin_raw;
wire s_mr_n, s_rclk, s_wclk, s_ow, s_iw, s_bm, s_fm, s_pkt;
wire [`DEV_W-1:0] s_id;
wire [`ADDR_W-1:0] s_raddr;
wire [`ADDR_W-1:0] s_waddr;
wire s_read_address_enable, s_write_address_enable, s_empty_status_strobe, s_full_status_strobe, s_tokin;

assign pin_raw = {MASTER_RESET_N, READ_CLK, WRITE_CLK, OUTPUT_WIDTH_STRAP,
   INPUT_WIDTH_STRAP, BUS_MATCHING_STRAP, FLAG_MODE_STRAP, PACKET_SELECT_STRAP,
   DEVICE_ID, READ_QUEUE_ADDRESS, WRITE_QUEUE_ADDRESS, READ_ADDRESS_ENABLE,
   WRITE_ADDRESS_ENABLE, EMPTY_STATUS_STROBE, FULL_STATUS_STROBE, TOKEN_CHAIN_IN};
assign {s_mr_n, s_rclk, s_wclk, s_ow, s_iw, s_bm, s_fm, s_pkt, s_id, s_raddr,
   s_waddr, s_read_address_enable, s_write_address_enable, s_empty_status_strobe, s_full_status_strobe, s_tokin} = sync2;

always @(posedge CORE_CLK or negedge RST_N) begin
   if (!RST_N) begin
      sync1 <= {`PIN_W{1'b0}};
      sync2 <= {`PIN_W{1'b0}};
   end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
   end
end

// Edges taken only from the second stage
reg rclk_d;
reg wclk_d;
wire rclk_rise = s_rclk & ~rclk_d;
wire wclk_rise = s_wclk & ~wclk_d;

always @(posedge CORE_CLK or negedge RST_N) begin
   if (!RST_N) begin
      rclk_d <= 1'b0;
      wclk_d <= 1'b0;
   end else begin
      rclk_d <= s_rclk;
      wclk_d <= s_wclk;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Straps caught while master reset is held low
reg polled_mode;
reg packet_mode;
reg [`DEV_W-1:0] dev_id;
reg ow_l, iw_l, bm_l;

always @(posedge CORE_CLK or negedge RST_N) begin
   if (!RST_N) begin
      polled_mode <= 1'b0;
      packet_mode <= 1'b0;
      dev_id <= 3'h0;
      ow_l <= 1'b0;
      iw_l <= 1'b0;
      bm_l <= 1'b0;
   end else if (!s_mr_n) begin
      polled_mode <= s_fm;
      packet_mode <= s_pkt;
      dev_id <= s_id;
      ow_l <= s_ow;
      iw_l <= s_iw;
      bm_l <= s_bm;
   end
end

// Bus matching: plain mode is 36/36; otherwise one side narrows
always @(posedge CORE_CLK or negedge RST_N) begin
   if (!RST_N) begin
      INPUT_BUS_WIDTH <= `WIDTH_X36;
      OUTPUT_BUS_WIDTH <= `WIDTH_X36;
   end else if (!bm_l) begin
      INPUT_BUS_WIDTH <= `WIDTH_X36;
      OUTPUT_BUS_WIDTH <= `WIDTH_X36;
   end else if (!iw_l) begin
      INPUT_BUS_WIDTH <= `WIDTH_X36;
      OUTPUT_BUS_WIDTH <= ow_l ? `WIDTH_X9 : `WIDTH_X18;
   end else begin
      INPUT_BUS_WIDTH <= ow_l ? `WIDTH_X9 : `WIDTH_X18;
      OUTPUT_BUS_WIDTH <= `WIDTH_X36;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Registers
reg [1:0] ctrl;
reg [`LEVEL_W-1:0] ae_thresh;
reg [`LEVEL_W-1:0] af_thresh;
reg wr_pend;
reg [`REG_ADDR_W-1:0] wr_addr;
wire addr_phase = HSEL & HTRANS[`HTRANS_NONSEQ_BIT] & HREADY;

assign HREADYOUT = 1'b1;
assign HRESP = 1'b0;

// Per-queue conditions, compared against the programmed thresholds
wire [`NUM_QUEUES-1:0] almost_empty;
wire [`NUM_QUEUES-1:0] almost_full;
genvar gi;
generate
   for (gi = 0; gi < `NUM_QUEUES; gi = gi + 1) begin : g_cmp
      wire [`LEVEL_W-1:0] lvl = QUEUE_LEVEL[gi*`LEVEL_W +: `LEVEL_W];
      assign almost_empty[gi] = (lvl <= ae_thresh);
      assign almost_full[gi] = (lvl >= af_thresh);
   end
endgenerate

reg [`QSEL_W-1:0] rd_q;
reg [`QSEL_W-1:0] wr_q;
reg rd_here;
reg wr_here;
reg rd_bus_on;
reg wr_bus_on;

reg [31:0] next_rdata;
always @* begin
   next_rdata = `ZERO32;
   case (HADDR[`REG_ADDR_W-1:0])
      `REG_CTRL: next_rdata = {30'h0, ctrl};
      `REG_AE_THRESH: next_rdata = {20'h00000, ae_thresh};
      `REG_AF_THRESH: next_rdata = {20'h00000, af_thresh};
      `REG_STATUS: next_rdata = {almost_full, almost_empty,
         1'b0, rd_q, 1'b0, wr_q, INPUT_BUS_WIDTH, OUTPUT_BUS_WIDTH,
         ALMOST_EMPTY_FLAG_N, ALMOST_FULL_FLAG_N, polled_mode, packet_mode};
      default: next_rdata = `ZERO32;
   endcase
end

always @(posedge CORE_CLK or negedge RST_N) begin
   if (!RST_N) begin
      ctrl <= `CTRL_RESET;
      ae_thresh <= `AE_THRESH_RESET;
      af_thresh <= `AF_THRESH_RESET;
      wr_pend <= 1'b0;
      wr_addr <= 4'h0;
      HRDATA <= `ZERO32;
   end else begin
      wr_pend <= addr_phase & HWRITE;
      wr_addr <= HADDR[`REG_ADDR_W-1:0];
      if (addr_phase & ~HWRITE) begin
         HRDATA <= next_rdata;
      end
      if (wr_pend) begin
         case (wr_addr)
            `REG_CTRL: ctrl <= HWDATA[1:0];
            `REG_AE_THRESH: ae_thresh <= HWDATA[`LEVEL_W-1:0];
            `REG_AF_THRESH: af_thresh <= HWDATA[`LEVEL_W-1:0];
            default: ctrl <= ctrl;
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Read side: queue selection, discrete flags and read-side bus
wire [`NUM_QUEUES-1:0] rd_status = packet_mode ? ~PACKET_READY : ~almost_empty;
wire rd_addr_hit = (s_raddr[`ADDR_W-1:`QSEL_W] == dev_id);

always @(posedge CORE_CLK or negedge RST_N) begin
   if (!RST_N) begin
      rd_q <= 3'h0;
      rd_here <= 1'b0;
      ALMOST_EMPTY_FLAG_N <= 1'b1;
      PACKET_READY_FLAG_N <= 1'b1;
      READ_SIDE_FLAG_BUS <= 8'hFF;
      rd_bus_on <= 1'b0;
   end else if (!s_mr_n) begin
      rd_here <= 1'b0;
      ALMOST_EMPTY_FLAG_N <= 1'b1;
      PACKET_READY_FLAG_N <= 1'b1;
      READ_SIDE_FLAG_BUS <= 8'hFF;
      rd_bus_on <= 1'b0;
   end else if (rclk_rise) begin
      if (s_read_address_enable) begin
         rd_q <= s_raddr[`QSEL_W-1:0];
         rd_here <= rd_addr_hit;
      end
      // Flags follow the queue held; a new selection shows one edge later
      ALMOST_EMPTY_FLAG_N <= ~(rd_here & almost_empty[rd_q]);
      PACKET_READY_FLAG_N <= ~(rd_here & packet_mode & PACKET_READY[rd_q]);
      if (polled_mode) begin
         READ_SIDE_FLAG_BUS <= rd_status;
         rd_bus_on <= 1'b1;
      end else if (s_empty_status_strobe) begin
         READ_SIDE_FLAG_BUS <= rd_status;
         rd_bus_on <= rd_addr_hit;
      end else if (ctrl[`CTRL_MIRROR] & rd_here) begin
         READ_SIDE_FLAG_BUS[rd_q] <= ~almost_empty[rd_q];
      end
   end
end

assign READ_SIDE_FLAG_BUS_OE_N = ~(rd_bus_on & ctrl[`CTRL_BUS_EN]);

////////////////////////////////////////////////////////////////////////////////
// Write side: queue selection, discrete flag, write-side bus and token
wire wr_addr_hit = (s_waddr[`ADDR_W-1:`QSEL_W] == dev_id);

always @(posedge CORE_CLK or negedge RST_N) begin
   if (!RST_N) begin
      wr_q <= 3'h0;
      wr_here <= 1'b0;
      ALMOST_FULL_FLAG_N <= 1'b1;
      WRITE_SIDE_FLAG_BUS <= 8'hFF;
      wr_bus_on <= 1'b0;
      TOKEN_CHAIN_OUT <= 1'b0;
   end else if (!s_mr_n) begin
      wr_here <= 1'b0;
      ALMOST_FULL_FLAG_N <= 1'b1;
      WRITE_SIDE_FLAG_BUS <= 8'hFF;
      wr_bus_on <= 1'b0;
      TOKEN_CHAIN_OUT <= 1'b0;
   end else if (wclk_rise) begin
      if (s_write_address_enable) begin
         wr_q <= s_waddr[`QSEL_W-1:0];
         wr_here <= wr_addr_hit;
      end
      ALMOST_FULL_FLAG_N <= ~(wr_here & almost_full[wr_q]);
      if (polled_mode) begin
         // Token held for one write-clock period, then passed on
         TOKEN_CHAIN_OUT <= s_tokin;
         wr_bus_on <= s_tokin;
         if (s_tokin) begin
            WRITE_SIDE_FLAG_BUS <= ~almost_full;
         end
      end else if (s_full_status_strobe & s_write_address_enable) begin
         WRITE_SIDE_FLAG_BUS <= ~almost_full;
         wr_bus_on <= wr_addr_hit;
      end else if (ctrl[`CTRL_MIRROR] & wr_here) begin
         WRITE_SIDE_FLAG_BUS[wr_q] <= ~almost_full[wr_q];
      end
   end
end

assign WRITE_SIDE_FLAG_BUS_OE_N = ~(wr_bus_on & ctrl[`CTRL_BUS_EN]);

endmodule // queue_level_flags

/* verif/queue_level_flags_props.sv */
// Purpose: Port checks for queue_level_flags
// Assumes: Pin clocks stay low for at least 6 core cycles between pulses
// Notes: Bound to the design top
module queue_level_flags_props (
   input wire CORE_CLK,
   input wire RST_N,
   input wire HREADYOUT,
   input wire MASTER_RESET_N,
   input wire READ_CLK,
   input wire WRITE_CLK,
   input wire OUTPUT_WIDTH_STRAP,
   input wire INPUT_WIDTH_STRAP,
   input wire BUS_MATCHING_STRAP,
   input wire ALMOST_EMPTY_FLAG_N,
   input wire ALMOST_FULL_FLAG_N,
   input wire [7:0] READ_SIDE_FLAG_BUS,
   input wire READ_SIDE_FLAG_BUS_OE_N,
   input wire WRITE_SIDE_FLAG_BUS_OE_N,
   input wire TOKEN_CHAIN_OUT,
   input wire [1:0] INPUT_BUS_WIDTH,
   input wire [1:0] OUTPUT_BUS_WIDTH
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////////////////////////////////////////
   a_zero_wait: assert property (HREADYOUT) else $error("wait state inserted");
   a_flags_idle_mrst: assert property (!MASTER_RESET_N [*5] |->
      ALMOST_EMPTY_FLAG_N && ALMOST_FULL_FLAG_N) else $error("flag low in master reset");
   a_buses_off_mrst: assert property (!MASTER_RESET_N [*5] |->
      READ_SIDE_FLAG_BUS_OE_N && WRITE_SIDE_FLAG_BUS_OE_N) else $error("bus on in reset");
   // Six idle samples put any pending pin event well behind us
   a_ae_read_only: assert property ((!READ_CLK && MASTER_RESET_N) [*6] |->
      $stable(ALMOST_EMPTY_FLAG_N)) else $error("empty flag moved off read clock");
   a_af_write_only: assert property ((!WRITE_CLK && MASTER_RESET_N) [*6] |->
      $stable(ALMOST_FULL_FLAG_N)) else $error("full flag moved off write clock");
   a_rbus_read_only: assert property ((!READ_CLK && MASTER_RESET_N) [*6] |->
      $stable(READ_SIDE_FLAG_BUS)) else $error("read bus moved off read clock");
   a_token_holds_bus: assert property (TOKEN_CHAIN_OUT |->
      !WRITE_SIDE_FLAG_BUS_OE_N) else $error("token out without write bus");
   a_width_full: assert property ((!MASTER_RESET_N && !BUS_MATCHING_STRAP) [*5] |->
      INPUT_BUS_WIDTH == 2'h2 && OUTPUT_BUS_WIDTH == 2'h2) else $error("width not x36");
   a_width_narrow_out: assert property ((!MASTER_RESET_N && BUS_MATCHING_STRAP &&
      !INPUT_WIDTH_STRAP) [*5] |-> INPUT_BUS_WIDTH == 2'h2 &&
      OUTPUT_BUS_WIDTH == (OUTPUT_WIDTH_STRAP ? 2'h0 : 2'h1)) else $error("narrow width");
endmodule // queue_level_flags_props

bind queue_level_flags queue_level_flags_props i_props (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
   .HREADYOUT(HREADYOUT), .MASTER_RESET_N(MASTER_RESET_N), .READ_CLK(READ_CLK),
   .WRITE_CLK(WRITE_CLK), .OUTPUT_WIDTH_STRAP(OUTPUT_WIDTH_STRAP),
   .INPUT_WIDTH_STRAP(INPUT_WIDTH_STRAP), .BUS_MATCHING_STRAP(BUS_MATCHING_STRAP),
   .ALMOST_EMPTY_FLAG_N(ALMOST_EMPTY_FLAG_N), .ALMOST_FULL_FLAG_N(ALMOST_FULL_FLAG_N),
   .READ_SIDE_FLAG_BUS(READ_SIDE_FLAG_BUS), .READ_SIDE_FLAG_BUS_OE_N(READ_SIDE_FLAG_BUS_OE_N),
   .WRITE_SIDE_FLAG_BUS_OE_N(WRITE_SIDE_FLAG_BUS_OE_N), .TOKEN_CHAIN_OUT(TOKEN_CHAIN_OUT),
   .INPUT_BUS_WIDTH(INPUT_BUS_WIDTH), .OUTPUT_BUS_WIDTH(OUTPUT_BUS_WIDTH));

/* verif/queue_ctrl_model.sv */
// Purpose: Queue controller pin clocks and token feed
// Assumes: Pin clocks are derived from the core clock, 5 high and 7 low
// Notes: The start token stands in for the chain head after master reset
module queue_ctrl_model (
   input wire CORE_CLK,
   input wire mrst_n,
   input wire fm,
   input wire tout,
   output logic rclk,
   output logic wclk,
   output wire tin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt = 4'h0;
   logic kick = 1'b0;
   ////////////////////////////////////////////////////////////////////////////
   initial rclk = 1'b0;
   initial wclk = 1'b0;
   always @(posedge CORE_CLK) begin
      cnt <= (cnt == 4'hB) ? 4'h0 : cnt + 4'h1;
      rclk <= cnt < 4'h5;
      wclk <= (cnt + 4'h4) % 4'hC < 4'h5;
      kick <= !mrst_n | (kick & !tout);
   end
   // Direct mode needs the token input held low
   assign tin = fm & (tout | kick);
endmodule // queue_ctrl_model

/* verif/test_queue_level_flags.sv */
// Purpose: Self-checking bench for queue_level_flags
// Assumes: Pin clocks come from the controller model
// Notes: Thresholds stay at reset values; levels drawn around them
`include "queue_flag_map.vh"
module test_queue_level_flags;
   timeunit 1ns;
   timeprecision 1ns;
   logic CORE_CLK = 0, RST_N = 0, hsel = 0, hwrite = 0, mrst_n = 0, hready, hresp;
   logic bm = 0, iw = 0, ow = 0, fm = 0, pkt = 0, raen = 0, waen = 0, empty_status_strobe = 0, full_status_strobe = 0;
   logic [1:0] htrans = 0, ibw, obw;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
   logic [2:0] dev = 0;
   logic [5:0] raddr = 0, waddr = 0;
   logic [95:0] lvl = 0;
   logic [7:0] prdy = 0, rbus, wbus, aev, afv;
   logic rclk, wclk, tin, tout, ae_n, af_n, pr_n, roe_n, woe_n, tok;
   int errors = 0, n_tests = 0;
   ////////////////////////////////////////////////////////////////////////////
   queue_level_flags i_dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .MASTER_RESET_N(mrst_n),
      .READ_CLK(rclk), .WRITE_CLK(wclk), .OUTPUT_WIDTH_STRAP(ow), .INPUT_WIDTH_STRAP(iw),
      .BUS_MATCHING_STRAP(bm), .FLAG_MODE_STRAP(fm), .PACKET_SELECT_STRAP(pkt),
      .DEVICE_ID(dev), .READ_QUEUE_ADDRESS(raddr), .WRITE_QUEUE_ADDRESS(waddr),
      .READ_ADDRESS_ENABLE(raen), .WRITE_ADDRESS_ENABLE(waen), .EMPTY_STATUS_STROBE(empty_status_strobe),
      .FULL_STATUS_STROBE(full_status_strobe), .TOKEN_CHAIN_IN(tin), .QUEUE_LEVEL(lvl), .PACKET_READY(prdy),
      .ALMOST_EMPTY_FLAG_N(ae_n), .ALMOST_FULL_FLAG_N(af_n), .PACKET_READY_FLAG_N(pr_n),
      .READ_SIDE_FLAG_BUS(rbus), .READ_SIDE_FLAG_BUS_OE_N(roe_n), .WRITE_SIDE_FLAG_BUS(wbus),
      .WRITE_SIDE_FLAG_BUS_OE_N(woe_n), .TOKEN_CHAIN_OUT(tout), .INPUT_BUS_WIDTH(ibw),
      .OUTPUT_BUS_WIDTH(obw));
   queue_ctrl_model i_ctrl (.CORE_CLK(CORE_CLK), .mrst_n(mrst_n), .fm(fm), .tout(tout),
      .rclk(rclk), .wclk(wclk), .tin(tin));
   always #25 CORE_CLK = ~CORE_CLK;
   ////////////////////////////////////////////////////////////////////////////
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge CORE_CLK); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge CORE_CLK); while (hready !== 1'b1);
      d = hrdata;
      chk("hresp", hresp, 32'h0);
   endtask
   // Waits for n falling pin edges, so the last rising edge has settled
   task ev(input logic w, input int n);
      repeat (n) if (w) @(negedge wclk); else @(negedge rclk);
      @(posedge CORE_CLK);
   endtask
   task mreset(input logic [4:0] s);
      mrst_n <= 0;
      {bm, iw, ow, fm, pkt} <= s;
      repeat (8) @(posedge CORE_CLK);
      mrst_n <= 1;
      ev(0, 1);
   endtask
   task draw;
      logic [95:0] v;
      for (int i = 0; i < 8; i++) begin
         v[12*i+:12] = $urandom_range(1) ? $urandom_range(32) : 4095 - $urandom_range(32);
      end
      v[47:0] = {12'hFEF, 12'h011, `AF_THRESH_RESET, `AE_THRESH_RESET};
      for (int i = 0; i < 8; i++) begin
         aev[i] = v[12*i+:12] <= `AE_THRESH_RESET;
         afv[i] = v[12*i+:12] >= `AF_THRESH_RESET;
      end
      lvl <= v;
      prdy <= $urandom;
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #1_000_000;
      errors++;
      conclude();
   end
   initial begin
      void'($urandom(62));
      dev = $urandom;
      repeat (20) @(posedge CORE_CLK);
      RST_N <= 1;
      ahb(0, 32'h0, 0);
      chk("ctrl", d, `CTRL_RESET);
      ahb(0, 32'h4, 0);
      chk("ae_thr", d, `AE_THRESH_RESET);
      ahb(0, 32'h8, 0);
      chk("af_thr", d, `AF_THRESH_RESET);
      draw();
      mreset(5'b00000);
      chk("width", {ibw, obw}, 4'hA);
      for (int q = 0; q < 9; q++) begin
         raddr <= {q < 8 ? dev : ~dev, q[2:0]};
         waddr <= {dev, q[2:0]};
         raen <= 1;
         waen <= 1;
         ev(0, 2);
         chk("ae_flag", ae_n, q < 8 ? !aev[q] : 1'b1);
         if (q < 8) chk("af_flag", af_n, !afv[q]);
      end
      ahb(0, 32'hC, 0);
      chk("status", d, {afv, aev, 16'h00AC});
      raddr <= {dev, 3'h0};
      empty_status_strobe <= 1;
      full_status_strobe <= 1;
      ev(0, 2);
      chk("rbus", {roe_n, rbus}, {1'b0, ~aev});
      chk("wbus", {woe_n, wbus}, {1'b0, ~afv});
      // Queue 0 flips both conditions so the mirrored line must change
      empty_status_strobe <= 0;
      full_status_strobe <= 0;
      lvl[11:0] <= 12'hFFF;
      ahb(1, 32'h0, 32'h3);
      ev(0, 2);
      chk("mirror_r", {roe_n, rbus}, {1'b0, ~aev[7:1], 1'b1});
      chk("mirror_w", {woe_n, wbus}, {1'b0, ~afv[7:1], 1'b0});
      ahb(1, 32'h0, 32'h0);
      // Control lands at the data-phase edge; look one edge later
      @(posedge CORE_CLK);
      chk("bus_off", {roe_n, woe_n}, 2'h3);
      ahb(1, 32'h0, 32'h1);
      ev(0, 1);
      raddr <= {~dev, 3'h0};
      empty_status_strobe <= 1;
      ev(0, 2);
      chk("rbus_other", roe_n, 1'b1);
      $display("direct mode done");
      empty_status_strobe <= 0;
      full_status_strobe <= 0;
      draw();
      mreset(5'b10111);
      chk("width_x9", {ibw, obw}, 4'h8);
      raddr <= {dev, 3'h5};
      tok = 0;
      repeat (40) @(posedge CORE_CLK) tok = tok | (tout === 1'b1);
      ev(1, 2);
      chk("token", tok, 1'b1);
      chk("pr_bus", {roe_n, rbus}, {1'b0, ~prdy});
      chk("wbus_poll", {woe_n, wbus}, {1'b0, ~afv});
      chk("pr_flag", pr_n, !prdy[5]);
      chk("ae_pkt", ae_n, !aev[5]);
      $display("polled packet mode done");
      mreset(5'b11000);
      chk("width_x18", {ibw, obw}, 4'h6);
      $display("width mode done");
      conclude();
   end
endmodule // test_queue_level_flags
